// File: design/pbo_pkg.sv
package pbo_pkg;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [3:0] PBO_ADDR_CTRL   = 4'h0;
	localparam logic [3:0] PBO_ADDR_RATE   = 4'h1;
	localparam logic [3:0] PBO_ADDR_AVG    = 4'h2;
	localparam logic [3:0] PBO_ADDR_TOTAL  = 4'h3;
	localparam logic [3:0] PBO_ADDR_TIME   = 4'h4;
	localparam logic [3:0] PBO_ADDR_BCOUNT = 4'h5;
	localparam logic [3:0] PBO_ADDR_BNUM   = 4'h6;
	localparam logic [3:0] PBO_ADDR_STAT   = 4'h7;

	// ----------------------------------------
	// value word layout: 24 bit bcd, dp[26:24], sign 27, ovf 28
	// ----------------------------------------
	localparam int PBO_DP_LSB   = 24;
	localparam int PBO_SIGN_BIT = 27;
	localparam int PBO_OVF_BIT  = 28;
	localparam int PBO_VAL_W    = 29;

	// ----------------------------------------
	// control register fields
	// ----------------------------------------
	localparam int PBO_CTRL_SRC_LSB  = 0;
	localparam int PBO_CTRL_MODE_LSB = 3;
	localparam int PBO_CTRL_UPD_BIT  = 5;

	localparam logic [2:0] PBO_SRC_OFF  = 3'h0;
	localparam logic [2:0] PBO_SRC_ONE  = 3'h1;
	localparam logic [2:0] PBO_SRC_TWO  = 3'h2;
	localparam logic [2:0] PBO_SRC_TRI  = 3'h3;
	localparam logic [2:0] PBO_SRC_FOUR = 3'h4;

	localparam logic [1:0] PBO_MODE_RATE  = 2'h0;
	localparam logic [1:0] PBO_MODE_SQRT  = 2'h1;
	localparam logic [1:0] PBO_MODE_BATCH = 2'h2;

	localparam logic [31:0] PBO_CTRL_RST = 32'h0000_0000;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int PBO_CLK_MHZ   = 50;
	localparam int PBO_READY_US  = 200;
	localparam int PBO_READY_CYC = PBO_READY_US * PBO_CLK_MHZ;
	localparam int PBO_CNT_W     = 14;

	typedef enum logic [1:0] {
		PBO_ST_IDLE  = 2'b00,
		PBO_ST_PULSE = 2'b01
	} pbo_state_t;

endpackage : pbo_pkg

// File: design/pbo_enable.sv
`timescale 1ns/1ps
`default_nettype none
module pbo_enable
	import pbo_pkg::*;
(
	input  wire logic mux_mode,
	input  wire logic single_line_enable_jumper,
	input  wire logic lower_select_polarity_jumper,
	input  wire logic upper_select_polarity_jumper,
	input  wire logic address_bit_polarity_jumper_c,
	input  wire logic address_bit_polarity_jumper_d,
	input  wire logic upper_digit_select_line,
	input  wire logic lower_digit_select_line,
	input  wire logic address_line_c,
	input  wire logic address_line_d,
	output logic      upper_en,
	output logic      lower_en,
	output logic      board_en
);
	// fitted jumper: line must be low; removed: high or open
	logic sel_u;
	logic sel_l;
	logic sel_c;
	logic sel_d;

	always_comb begin
		sel_u = upper_digit_select_line ^ upper_select_polarity_jumper; // [R10]
		sel_l = lower_digit_select_line ^ lower_select_polarity_jumper; // [R11]
		sel_c = address_line_c ^ address_bit_polarity_jumper_c; // [R13]
		sel_d = address_line_d ^ address_bit_polarity_jumper_d; // [R13]
		upper_en = mux_mode & sel_u; // [R9]
		lower_en = mux_mode & ~sel_u & sel_l; // [R11]
		if (mux_mode) begin
			board_en = upper_en | lower_en;
		end else if (single_line_enable_jumper) begin
			board_en = sel_u; // [R12]
		end else begin
			board_en = sel_u & sel_l & sel_c & sel_d; // [R13] [R14]
		end
	end
endmodule : pbo_enable
`default_nettype wire

// File: design/pbo_pulse.sv
`timescale 1ns/1ps
`default_nettype none
module pbo_pulse
	import pbo_pkg::*;
(
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic start,
	output logic      ready_n_q
);
	// ----------------------------------------
	// data-ready low pulse timer
	// ----------------------------------------
	localparam logic [PBO_CNT_W-1:0] LAST = PBO_CNT_W'(PBO_READY_CYC - 1);

	pbo_state_t           state_q, state_d;
	logic [PBO_CNT_W-1:0] cnt_q, cnt_d;
	logic                 ready_n_d;

	always_comb begin
		state_d   = state_q;
		cnt_d     = cnt_q;
		ready_n_d = ready_n_q;
		case (state_q)
			PBO_ST_IDLE: begin
				if (start) begin
					state_d   = PBO_ST_PULSE;
					cnt_d     = '0;
					ready_n_d = 1'b0; // [R6] [R19]
				end
			end
			PBO_ST_PULSE: begin
				if (start) begin
					cnt_d = '0;
				end else if (cnt_q == LAST) begin
					state_d   = PBO_ST_IDLE;
					ready_n_d = 1'b1; // [R6]
				end else begin
					cnt_d = cnt_q + 1'b1; // [R19]
				end
			end
			default: begin
				state_d   = PBO_ST_IDLE;
				ready_n_d = 1'b1;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q   <= PBO_ST_IDLE;
			cnt_q     <= '0;
			ready_n_q <= 1'b1;
		end else begin
			state_q   <= state_d;
			cnt_q     <= cnt_d;
			ready_n_q <= ready_n_d;
		end
	end

	pulse_len_a: assert property (@(posedge clk) disable iff (sys_rst) // [R6]
		$fell(ready_n_q) |-> !ready_n_q [*8])
		else $error("ready pulse too short");
endmodule : pbo_pulse
`default_nettype wire

// File: design/pbo_port.sv
// Overview of operation
// R1: six parallel BCD digits, four lines each
// R2: source select zero disables outputs
// R3: source select picks value per mode
// R4: hold low freezes all outputs; code freezes the latch only, enables still follow src and board select
// R5: release refreshes all digits together
// R6: data-ready low about 200 us per update
// R7: data-ready never inverted by polarity
// R8: overflow line driven only with jumper
// R9: multiplex puts upper digits on lower lines
// R10: upper select sense set by jumper
// R11: lower digits shown when upper not enabled
// R12: single-line enable uses one select line
// R13: four address lines xor jumper, anded
// R14: reader drives address lines per jumpers
// R15: disabled board floats its outputs
// R16: polarity jumper inverts data and point
// R17: three-bit decimal point position code
// R18: 8-4-2-1 digits plus sign line
// R19: pulse timed by counter, starts on update
`timescale 1ns/1ps
`default_nettype none
module pbo_port
	import pbo_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        freeze_input,
	input  wire logic        upper_digit_select_line,
	input  wire logic        lower_digit_select_line,
	input  wire logic        address_line_c,
	input  wire logic        address_line_d,
	input  wire logic        overflow_route_jumper,
	input  wire logic        multiplex_jumper_first,
	input  wire logic        single_line_enable_jumper,
	input  wire logic        multiplex_jumper_third,
	input  wire logic        lower_select_polarity_jumper,
	input  wire logic        upper_select_polarity_jumper,
	input  wire logic        address_bit_polarity_jumper_c,
	input  wire logic        address_bit_polarity_jumper_d,
	input  wire logic        negative_true_jumper,
	output logic      [23:0] bcd_out,
	output logic      [23:0] bcd_oe,
	output logic      [2:0]  dp_out,
	output logic      [2:0]  dp_oe,
	output logic             polarity_out,
	output logic             polarity_oe,
	output logic             overflow_output_line,
	output logic             overflow_oe,
	output logic             update_marker_line
);
	// ----------------------------------------
	// software registers
	// ----------------------------------------
	logic [31:0]          ctrl_q, ctrl_d;
	logic [PBO_VAL_W-1:0] val_q [6];
	logic [PBO_VAL_W-1:0] val_d [6];
	logic [31:0]          rdata_d;
	logic [2:0]           src;
	logic [2:0]           nsrc;
	logic [1:0]           mode;
	logic                 upd_req;

	// the latch takes the source written alongside the update request
	assign src     = ctrl_q[PBO_CTRL_SRC_LSB +: 3];
	assign nsrc    = ctrl_d[PBO_CTRL_SRC_LSB +: 3];
	assign mode    = ctrl_d[PBO_CTRL_MODE_LSB +: 2];
	assign upd_req = reg_wr && reg_addr == PBO_ADDR_CTRL && reg_wdata[PBO_CTRL_UPD_BIT];

	// ----------------------------------------
	// output latch and pin state
	// ----------------------------------------
	logic [PBO_VAL_W-1:0] sel_val;
	logic [PBO_VAL_W-1:0] lat_q, lat_d;
	logic                 pend_q, pend_d;
	logic                 upd;
	logic                 mux_mode;
	logic                 upper_en;
	logic                 lower_en;
	logic                 board_en;
	logic                 inv;
	logic                 ready_n;
	logic [23:0]          bcd_d;
	logic [23:0]          bcd_oe_d;
	logic [2:0]           dp_d;
	logic                 drive;

	assign mux_mode = multiplex_jumper_first & single_line_enable_jumper & multiplex_jumper_third;
	assign inv      = negative_true_jumper;

	always_comb begin
		ctrl_d = ctrl_q;
		for (int i = 0; i < 6; i++) begin
			val_d[i] = val_q[i];
		end
		if (reg_wr) begin
			case (reg_addr)
				PBO_ADDR_CTRL:   ctrl_d = {26'h0, reg_wdata[5:0] & 6'h1F};
				PBO_ADDR_RATE:   val_d[0] = reg_wdata[PBO_VAL_W-1:0];
				PBO_ADDR_AVG:    val_d[1] = reg_wdata[PBO_VAL_W-1:0];
				PBO_ADDR_TOTAL:  val_d[2] = reg_wdata[PBO_VAL_W-1:0];
				PBO_ADDR_TIME:   val_d[3] = reg_wdata[PBO_VAL_W-1:0];
				PBO_ADDR_BCOUNT: val_d[4] = reg_wdata[PBO_VAL_W-1:0];
				PBO_ADDR_BNUM:   val_d[5] = reg_wdata[PBO_VAL_W-1:0];
				default: begin
				end
			endcase
		end
		rdata_d = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				PBO_ADDR_CTRL:   rdata_d = ctrl_q;
				PBO_ADDR_RATE:   rdata_d = {3'h0, val_q[0]};
				PBO_ADDR_AVG:    rdata_d = {3'h0, val_q[1]};
				PBO_ADDR_TOTAL:  rdata_d = {3'h0, val_q[2]};
				PBO_ADDR_TIME:   rdata_d = {3'h0, val_q[3]};
				PBO_ADDR_BCOUNT: rdata_d = {3'h0, val_q[4]};
				PBO_ADDR_BNUM:   rdata_d = {3'h0, val_q[5]};
				PBO_ADDR_STAT:   rdata_d = {28'h0, pend_q, board_en, ~ready_n, freeze_input};
				default:         rdata_d = 32'h0000_0000;
			endcase
		end
	end

	// source mux per mode
	always_comb begin
		sel_val = '0;
		if (mode == PBO_MODE_BATCH) begin
			case (nsrc)
				PBO_SRC_ONE: sel_val = val_q[4]; // [R3]
				PBO_SRC_TWO: sel_val = val_q[5]; // [R3]
				default:     sel_val = '0;
			endcase
		end else begin
			case (nsrc)
				PBO_SRC_ONE:  sel_val = val_q[0]; // [R3]
				PBO_SRC_TWO:  sel_val = val_q[1]; // [R3]
				PBO_SRC_TRI:  sel_val = val_q[2]; // [R3]
				PBO_SRC_FOUR: sel_val = val_q[3]; // [R3]
				default:      sel_val = '0;
			endcase
		end
	end

	// one strobe loads the whole latch; a request under hold waits for release
	always_comb begin
		upd    = (upd_req | pend_q) & freeze_input; // [R4] [R5]
		pend_d = (pend_q | upd_req) & ~upd;
		lat_d  = upd ? sel_val : lat_q; // [R5]
	end

	pbo_enable u_enable (
		.mux_mode                      (mux_mode),
		.single_line_enable_jumper     (single_line_enable_jumper),
		.lower_select_polarity_jumper  (lower_select_polarity_jumper),
		.upper_select_polarity_jumper  (upper_select_polarity_jumper),
		.address_bit_polarity_jumper_c (address_bit_polarity_jumper_c),
		.address_bit_polarity_jumper_d (address_bit_polarity_jumper_d),
		.upper_digit_select_line       (upper_digit_select_line),
		.lower_digit_select_line       (lower_digit_select_line),
		.address_line_c                (address_line_c),
		.address_line_d                (address_line_d),
		.upper_en                      (upper_en),
		.lower_en                      (lower_en),
		.board_en                      (board_en)
	);

	pbo_pulse u_pulse (
		.clk       (clk),
		.sys_rst   (sys_rst),
		.start     (upd), // [R19]
		.ready_n_q (ready_n)
	);

	always_comb begin
		drive = board_en & (src != PBO_SRC_OFF); // [R2] [R15]
		if (mux_mode) begin
			bcd_d = {12'h000, upper_en ? lat_q[23:12] : lat_q[11:0]} ^ {12'h000, {12{inv}}}; // [R9] [R11]
			bcd_oe_d = {12'h000, {12{drive}}};
		end else begin
			bcd_d    = lat_q[23:0] ^ {24{inv}}; // [R1] [R16] [R18]
			bcd_oe_d = {24{drive}}; // [R1]
		end
		dp_d = lat_q[PBO_DP_LSB +: 3] ^ {3{inv}}; // [R16] [R17]
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ctrl_q    <= PBO_CTRL_RST;
			for (int i = 0; i < 6; i++) begin
				val_q[i] <= '0;
			end
			reg_rdata <= 32'h0000_0000;
			lat_q     <= '0;
			pend_q    <= 1'b0;
			bcd_out   <= 24'h000000;
			bcd_oe    <= 24'h000000;
			dp_out    <= 3'h0;
			dp_oe     <= 3'h0;
			polarity_out         <= 1'b0;
			polarity_oe          <= 1'b0;
			overflow_output_line <= 1'b0;
			overflow_oe          <= 1'b0;
			update_marker_line   <= 1'b1;
		end else begin
			ctrl_q    <= ctrl_d;
			for (int i = 0; i < 6; i++) begin
				val_q[i] <= val_d[i];
			end
			reg_rdata <= rdata_d;
			lat_q     <= lat_d;
			pend_q    <= pend_d;
			bcd_out   <= bcd_d;
			bcd_oe    <= bcd_oe_d;
			dp_out    <= dp_d;
			dp_oe     <= {3{drive}};
			polarity_out         <= lat_q[PBO_SIGN_BIT] ^ inv; // [R18]
			polarity_oe          <= drive;
			overflow_output_line <= lat_q[PBO_OVF_BIT] ^ inv;
			overflow_oe          <= drive & overflow_route_jumper; // [R8]
			update_marker_line   <= ready_n; // [R7]
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	hold_freeze_a: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
		!freeze_input |=> $stable(lat_q))
		else $error("latch changed under hold");
	off_float_a: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
		src == PBO_SRC_OFF |=> bcd_oe == 24'h000000)
		else $error("outputs driven while disabled");
	ovf_route_a: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
		!overflow_route_jumper |=> !overflow_oe)
		else $error("overflow driven without jumper");
	marker_start_a: assert property (@(posedge clk) disable iff (sys_rst) // [R19]
		upd |=> ##1 !update_marker_line)
		else $error("marker did not follow update");
	float_dis_a: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
		!board_en |=> bcd_oe == 24'h000000 && dp_oe == 3'h0)
		else $error("driven while board disabled");
	mux_upper_a: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
		mux_mode |=> bcd_oe[23:12] == 12'h000)
		else $error("upper lines driven in multiplex");
	pol_data_a: assert property (@(posedge clk) disable iff (sys_rst) // [R16]
		!mux_mode |=> bcd_out == ($past(lat_q[23:0]) ^ {24{$past(inv)}}))
		else $error("data polarity wrong");
	dp_code_a: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
		1'b1 |=> dp_out == ($past(lat_q[26:24]) ^ {3{$past(inv)}}))
		else $error("decimal point code wrong");

	// ----------------------------------------
	// update path checks
	// ----------------------------------------
	hold_pend_a: assert property (@(posedge clk) disable iff (sys_rst) // [R4]
		upd_req && !freeze_input |=> pend_q)
		else $error("update under hold was lost");

	release_load_a: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
		pend_q && freeze_input |=> !pend_q && lat_q == $past(sel_val))
		else $error("release did not load latch");

	upd_load_a: assert property (@(posedge clk) disable iff (sys_rst) // [R5]
		upd |=> lat_q == $past(sel_val))
		else $error("update did not load all digits");

	rate_src_a: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
		upd && mode != PBO_MODE_BATCH && nsrc == PBO_SRC_TRI |=> lat_q == $past(val_q[2]))
		else $error("rate mode source wrong");

	batch_src_a: assert property (@(posedge clk) disable iff (sys_rst) // [R3]
		upd && mode == PBO_MODE_BATCH && nsrc == PBO_SRC_TWO |=> lat_q == $past(val_q[5]))
		else $error("batch mode source wrong");

	off_src_a: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
		upd && nsrc == PBO_SRC_OFF |=> lat_q == '0)
		else $error("disabled source loaded data");

	// ----------------------------------------
	// pin checks
	// ----------------------------------------
	off_side_a: assert property (@(posedge clk) disable iff (sys_rst) // [R2]
		src == PBO_SRC_OFF |=> dp_oe == 3'h0 && !polarity_oe && !overflow_oe)
		else $error("side lines driven while disabled");

	side_dis_a: assert property (@(posedge clk) disable iff (sys_rst) // [R15]
		!board_en |=> !polarity_oe && !overflow_oe)
		else $error("side lines driven while deselected");

	drive_en_a: assert property (@(posedge clk) disable iff (sys_rst) // [R1]
		board_en && src != PBO_SRC_OFF && !mux_mode |=> bcd_oe == 24'hFFFFFF)
		else $error("digit lines not driven");

	ovf_data_a: assert property (@(posedge clk) disable iff (sys_rst) // [R8]
		1'b1 |=> overflow_output_line == ($past(lat_q[PBO_OVF_BIT]) ^ $past(inv)))
		else $error("overflow value wrong");

	marker_pol_a: assert property (@(posedge clk) disable iff (sys_rst) // [R7]
		1'b1 |=> update_marker_line == $past(ready_n))
		else $error("marker level wrong");

	sign_pol_a: assert property (@(posedge clk) disable iff (sys_rst) // [R18]
		1'b1 |=> polarity_out == ($past(lat_q[PBO_SIGN_BIT]) ^ $past(inv)))
		else $error("sign line wrong");

	dp_drive_a: assert property (@(posedge clk) disable iff (sys_rst) // [R17]
		1'b1 |=> dp_oe == {3{$past(drive)}})
		else $error("point line enable wrong");

	// ----------------------------------------
	// board select checks
	// ----------------------------------------
	mux_high_a: assert property (@(posedge clk) disable iff (sys_rst) // [R9]
		mux_mode && upper_en |=> bcd_out[11:0] == ($past(lat_q[23:12]) ^ {12{$past(inv)}}))
		else $error("upper digits not on shared lines");

	mux_low_a: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
		mux_mode && !upper_en |=> bcd_out[11:0] == ($past(lat_q[11:0]) ^ {12{$past(inv)}}))
		else $error("lower digits not on shared lines");

	upper_sense_a: assert property (@(posedge clk) disable iff (sys_rst) // [R10]
		mux_mode |-> upper_en == (upper_digit_select_line ^ upper_select_polarity_jumper))
		else $error("upper select sense wrong");

	lower_gate_a: assert property (@(posedge clk) disable iff (sys_rst) // [R11]
		upper_en |-> !lower_en)
		else $error("both digit groups enabled");

	single_line_a: assert property (@(posedge clk) disable iff (sys_rst) // [R12]
		!mux_mode && single_line_enable_jumper
			|-> board_en == (upper_digit_select_line ^ upper_select_polarity_jumper))
		else $error("single line enable wrong");

	addr_match_a: assert property (@(posedge clk) disable iff (sys_rst) // [R13]
		!single_line_enable_jumper |-> board_en == (
			(upper_digit_select_line ^ upper_select_polarity_jumper)
			& (lower_digit_select_line ^ lower_select_polarity_jumper)
			& (address_line_c ^ address_bit_polarity_jumper_c)
			& (address_line_d ^ address_bit_polarity_jumper_d)))
		else $error("board address decode wrong");
endmodule : pbo_port
`default_nettype wire

// File: testbench/pbo_reader.sv
`timescale 1ns/1ps
`default_nettype none
module pbo_reader
	import pbo_pkg::*;
(
	input  wire logic        clk,
	input  wire logic [23:0] bcd_out,
	input  wire logic [23:0] bcd_oe,
	input  wire logic        update_marker_line,
	input  wire logic        hold_req,
	output logic             freeze_input,
	output logic      [23:0] bus_lines,
	output var int           marks
);
	logic mark_q = 1'b1;

	// undriven lines read high through the reader's pull-ups
	assign bus_lines = (bcd_out & bcd_oe) | ~bcd_oe;
	// hold is pulled low by the reader to freeze the port
	assign freeze_input = ~hold_req;

	// counts falling edges of the data-ready marker
	initial marks = 0;
	always @(posedge clk) begin
		mark_q <= update_marker_line;
		if (mark_q && !update_marker_line)
			marks <= marks + 1;
	end
endmodule : pbo_reader
`default_nettype wire

// File: testbench/test_parallel_bcd_output_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_parallel_bcd_output_port;
	import pbo_pkg::*;
	logic        clk, sys_rst, reg_wr, reg_rd, hold_req, freeze_input;
	logic        update_marker_line, polarity_out, polarity_oe;
	logic        overflow_output_line, overflow_oe;
	logic [3:0]  reg_addr, a;
	logic [8:0]  j;
	logic [2:0]  sr, dp_out, dp_oe;
	logic [1:0]  m;
	logic [23:0] bcd_out, bcd_oe, bus_lines;
	logic [31:0] reg_wdata, reg_rdata, s, w, v[1:6];
	logic [31:0] seed = 32'h11;
	int          marks, n, error_cnt, samples_checked;
	wire logic overflow_route_jumper = j[0], multiplex_jumper_first = j[1];
	wire logic single_line_enable_jumper = j[2], multiplex_jumper_third = j[3];
	wire logic upper_select_polarity_jumper = j[4], lower_select_polarity_jumper = j[5];
	wire logic address_bit_polarity_jumper_c = j[6], address_bit_polarity_jumper_d = j[7];
	wire logic negative_true_jumper = j[8], upper_digit_select_line = a[0];
	wire logic lower_digit_select_line = a[1], address_line_c = a[2], address_line_d = a[3];

	pbo_port dut (
		.clk                           (clk),
		.sys_rst                       (sys_rst),
		.reg_addr                      (reg_addr),
		.reg_wdata                     (reg_wdata),
		.reg_wr                        (reg_wr),
		.reg_rd                        (reg_rd),
		.reg_rdata                     (reg_rdata),
		.freeze_input                  (freeze_input),
		.upper_digit_select_line       (upper_digit_select_line),
		.lower_digit_select_line       (lower_digit_select_line),
		.address_line_c                (address_line_c),
		.address_line_d                (address_line_d),
		.overflow_route_jumper         (overflow_route_jumper),
		.multiplex_jumper_first        (multiplex_jumper_first),
		.single_line_enable_jumper     (single_line_enable_jumper),
		.multiplex_jumper_third        (multiplex_jumper_third),
		.lower_select_polarity_jumper  (lower_select_polarity_jumper),
		.upper_select_polarity_jumper  (upper_select_polarity_jumper),
		.address_bit_polarity_jumper_c (address_bit_polarity_jumper_c),
		.address_bit_polarity_jumper_d (address_bit_polarity_jumper_d),
		.negative_true_jumper          (negative_true_jumper),
		.bcd_out                       (bcd_out),
		.bcd_oe                        (bcd_oe),
		.dp_out                        (dp_out),
		.dp_oe                         (dp_oe),
		.polarity_out                  (polarity_out),
		.polarity_oe                   (polarity_oe),
		.overflow_output_line          (overflow_output_line),
		.overflow_oe                   (overflow_oe),
		.update_marker_line            (update_marker_line)
	);
	pbo_reader reader (
		.clk                (clk),
		.bcd_out            (bcd_out),
		.bcd_oe             (bcd_oe),
		.update_marker_line (update_marker_line),
		.hold_req           (hold_req),
		.freeze_input       (freeze_input),
		.bus_lines          (bus_lines),
		.marks              (marks)
	);

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic logic [31:0] mkval();
		logic [31:0] x;
		x = 32'h0;
		for (int i = 0; i < 6; i++)
			x[4*i+:4] = 4'(rnd() % 10);
		x[26:24] = 3'(1 + rnd() % 6);
		x[28:27] = 2'(rnd());
		return x;
	endfunction : mkval

	function automatic logic [31:0] ctl();
		return {26'h0, 1'b1, m, sr};
	endfunction : ctl

	function automatic logic on();
		if (sr == 3'h0)
			return 1'b0;
		if (j[2])
			return a[0] ^ j[4];
		return &(a ^ j[7:4]);
	endfunction : on

	task automatic chk(logic [31:0] g, logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk

	task automatic done(string t);
		$display("test %s done", t);
	endtask : done

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : summarize

	task automatic wr(logic [3:0] ad, logic [31:0] d);
		reg_addr <= ad;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask : wr

	task automatic rd(logic [3:0] ad, logic [31:0] e);
		reg_addr <= ad;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
		@(posedge clk);
	endtask : rd

	task automatic pins();
		logic [31:0] x;
		logic        e;
		x = sr == 3'h0 ? 32'h0 : v[m == 2'h2 ? sr + 4 : sr];
		x = j[8] ? ~x : x;
		e = on();
		if (j[1]) begin
			chk(bus_lines[11:0], sr == 3'h0 ? 12'hFFF : (a[0] ^ j[4]) ? x[23:12]
				: (a[1] ^ j[5]) ? x[11:0] : 12'hFFF);
		end else begin
			chk(bus_lines, e ? x[23:0] : 24'hFFFFFF);
			chk({dp_oe, polarity_oe}, e ? 4'hF : 4'h0);
			if (e)
				chk({polarity_out, dp_out}, x[27:24]);
			chk(overflow_oe, j[0] & e);
			if (j[0] & e)
				chk(overflow_output_line, x[28]);
		end
	endtask : pins

	task automatic look(logic mk);
		repeat (4) @(posedge clk);
		#1;
		chk(update_marker_line, mk);
		pins();
		@(posedge clk);
	endtask : look

	task automatic upd();
		wr(4'h0, ctl());
		look(1'b0);
	endtask : upd

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		sys_rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 32'h0;
		hold_req = 1'b0;
		j = 9'h015;
		a = 4'h0;
		sr = 3'h1;
		m = 2'h0;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		#1;
		chk(bcd_oe, 32'h0);
		chk(update_marker_line, 1'b1);
		chk(reg_rdata, 32'h0);
		@(posedge clk);
		for (int i = 1; i < 7; i++) begin
			v[i] = mkval();
			wr(4'(i), v[i]);
			rd(4'(i), v[i] & 32'h1FFFFFFF);
		end
		rd(4'hF, 32'h0);
		done("registers");
		wr(4'h0, ctl());
		n = 0;
		repeat (12000) begin
			#1;
			if (!update_marker_line)
				n++;
			@(posedge clk);
		end
		chk(n, PBO_READY_CYC);
		@(posedge clk);
		done("marker");
		n = marks;
		hold_req <= 1'b1;
		w = mkval();
		wr(4'h1, w);
		wr(4'h0, ctl());
		look(1'b1);
		chk(marks, n);
		v[1] = w;
		hold_req <= 1'b0;
		look(1'b0);
		chk(marks, n + 1);
		done("hold");
		for (int k = 0; k < 15; k++) begin
			m = 2'(k / 5);
			sr = 3'(k % 5);
			if (m != 2'h2 || sr < 3'h3) begin
				upd();
				rd(4'h0, {27'h0, m, sr});
			end
		end
		done("sources");
		m = 2'h0;
		for (int k = 0; k < 60; k++) begin
			s = rnd();
			j <= {s[8:4], k > 39, k > 19, k > 39, s[0]};
			// reader matches the jumpers on every fourth pass
			a <= (k % 4 == 0) ? ~s[7:4] : s[12:9];
			sr = 3'(1 + s[13]);
			upd();
		end
		done("select");
		summarize();
	end

	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		summarize();
	end
endmodule : test_parallel_bcd_output_port
`default_nettype wire
